// File: logic/pm_capability_word.sv
/*
 * Power-management capability block of a bus-to-card bridge function: list entries,
 * the read-only capability word, the wake status/enable bits and the open-drain wake pin.
 * Assumes a configuration access port decoded for this function, one dword per request,
 * and an external wire resolving the wake pin from its output enable.
 */
// Operation
// [R01] sixteen-bit read-only capability word sits at offsets DEh-DFh
// [R02] bits 11-14 flag wake ability from D0, D1, D2, D3hot
// [R03] bit 15 set only when wake works from auxiliary power
// [R04] wake request held until status cleared or enable cleared; a card status request not yet in status ends when its pin falls
// [R05] bit 10 reads one: deep doze state supported
// [R06] bit 9 reads one: light doze state supported
// [R07] auxiliary current field bits 8-6 reads zero
// [R08] bit 5 and reserved bit 4 read zero
// [R09] bit 3 reads one: wake generation needs the bus clock
// [R10] card detect, ready/busy, battery warning wakes need the running clock
// [R11] card status change wakes without any bus clock
// [R12] bits 2-0 read 010b interface revision
// [R13] writing one clears wake status; writing zero does nothing
// [R14] wake request asserted only while wake enable is set
// [R15] writes to the capability word are ignored
`timescale 1ns/100ps
`include "pm_cap_regs.svh"

module pm_capability_word #(
	parameter logic [3:0] WAKE_STATE_MASK = `PM_CAP_STATE_MASK_VAL,
	parameter logic AUX_WAKE = `PM_CAP_AUX_WAKE_VAL
) (
	input wire logic clock_in,
	input wire logic rst_in,
	input wire logic [7:0] cfg_addr_in,
	input wire logic cfg_rd_in,
	input wire logic cfg_wr_in,
	input wire logic [3:0] cfg_be_in,
	input wire logic [31:0] cfg_wdata_in,
	output logic [31:0] cfg_rdata_out,
	output logic cfg_ack_out,
	input wire logic card_detect_in,
	input wire logic ready_busy_in,
	input wire logic battery_warn_in,
	input wire logic card_status_chg_in,
	output logic wake_pin_out,
	output logic wake_pin_oe_out,
	output logic [1:0] power_state_out
);
	logic [15:0] cap_word;
	logic [31:0] cap_dword;
	logic [31:0] cs_dword;
	logic [3:0] src_level;
	logic [3:0] src_change;
	logic state_allowed;
	logic clocked_event;
	logic status_event;
	logic dword_hit_cs;
	logic dword_hit_cap;
	logic status_clear;
	logic wake_status_flag_r;
	logic wake_status_flag_nxt;
	logic wake_enable_flag_r;
	logic [3:0] data_select_r;
	pm_cap_pkg::power_state_e power_state_r;
	logic [31:0] rdata_r;
	logic ack_r;

	// capability word built from fixed fields; no storage, so writes cannot alter it
	always_comb begin
		cap_word = 16'h0000;
		cap_word[`PM_CAP_AUX_WAKE_BIT] = AUX_WAKE; // [R03]
		cap_word[`PM_CAP_STATE_MASK_LSB +: 4] = WAKE_STATE_MASK; // [R02]
		cap_word[`PM_CAP_DEEP_DOZE_BIT] = 1'h1; // [R05]
		cap_word[`PM_CAP_LIGHT_DOZE_BIT] = 1'h1; // [R06]
		cap_word[`PM_CAP_AUX_CUR_LSB +: 3] = `PM_CAP_AUX_CUR_VAL; // [R07]
		cap_word[`PM_CAP_DSI_BIT] = 1'h0; // [R08]
		cap_word[`PM_CAP_BUS_CLK_BIT] = 1'h1; // [R09]
		cap_word[2:0] = `PM_CAP_VERSION_VAL; // [R12]
	end

	// dword at DCh: id, next pointer, then the capability word in the upper half
	assign cap_dword = {cap_word, `PM_NEXT_PTR_VAL, `PM_CAP_ID_VAL}; // [R01]

	// dword at E0h: control/status in the low three bytes, data register on top
	always_comb begin
		cs_dword = 32'h0000_0000;
		cs_dword[31:24] = `PM_DATA_VAL;
		cs_dword[`PM_CS_BPCC_BIT] = 1'h1;
		cs_dword[`PM_CS_B2B3_BIT] = 1'h1;
		cs_dword[`PM_CS_STATUS_BIT] = wake_status_flag_r;
		cs_dword[`PM_CS_SCALE_LSB +: 2] = `PM_CS_SCALE_VAL;
		cs_dword[`PM_CS_SELECT_LSB +: 4] = data_select_r;
		cs_dword[`PM_CS_ENABLE_BIT] = wake_enable_flag_r;
		cs_dword[`PM_CS_STATE_LSB +: 2] = power_state_r;
	end

	// dword index of a byte offset; the low two bits only pick byte lanes
	function automatic logic [5:0] dword_of(input logic [7:0] ofs);
		return ofs[7:2];
	endfunction

	// dword decode on the upper address bits; byte lanes pick fields
	assign dword_hit_cap = (cfg_addr_in[7:2] == dword_of(`PM_CAP_ID_OFS));
	assign dword_hit_cs = (cfg_addr_in[7:2] == dword_of(`PM_CTRL_STAT_OFS));

	// wake sources pass two flops; the card status input also has a clockless path
	wake_event_sync #(
		.WIDTH(4)
	) u_sync (
		.clock_in(clock_in),
		.rst_in(rst_in),
		.src_in({card_status_chg_in, battery_warn_in, ready_busy_in, card_detect_in}),
		.level_out(src_level),
		.change_out(src_change)
	);

	// is the current power state one the mask allows waking from
	assign state_allowed = WAKE_STATE_MASK[power_state_r]; // [R02]

	// detect, ready/busy and battery warning are only seen while the clock runs
	assign clocked_event = |src_change[2:0]; // [R10]
	// card status change counts on its settled rising level
	assign status_event = state_allowed & (clocked_event | (src_change[3] & src_level[3]));

	// write-one-to-clear on byte lane 1 of the control/status dword
	assign status_clear = cfg_wr_in & dword_hit_cs & cfg_be_in[1] &
		cfg_wdata_in[`PM_CS_STATUS_BIT]; // [R13]

	// status sets regardless of enable; an event in the clearing cycle wins
	always_comb begin
		wake_status_flag_nxt = wake_status_flag_r;
		if (status_clear) begin
			wake_status_flag_nxt = 1'h0; // [R13]
		end
		if (status_event) begin
			wake_status_flag_nxt = 1'h1;
		end
	end

	always_ff @(posedge clock_in) begin
		if (rst_in) begin
			wake_status_flag_r <= 1'h0;
		end else begin
			wake_status_flag_r <= wake_status_flag_nxt; // [R04]
		end
	end

	// writable control fields; the capability dword has no write path at all
	always_ff @(posedge clock_in) begin
		if (rst_in) begin
			wake_enable_flag_r <= 1'h0;
			data_select_r <= 4'h0;
			power_state_r <= pm_cap_pkg::PS_D0;
		end else if (cfg_wr_in && dword_hit_cs) begin // [R15]
			if (cfg_be_in[0]) begin
				power_state_r <= pm_cap_pkg::power_state_e'(cfg_wdata_in[1:0]);
			end
			if (cfg_be_in[1]) begin
				wake_enable_flag_r <= cfg_wdata_in[`PM_CS_ENABLE_BIT];
				data_select_r <= cfg_wdata_in[`PM_CS_SELECT_LSB +: 4];
			end
		end
	end

	// read data registered; other dwords of the space return zero here
	always_ff @(posedge clock_in) begin
		if (rst_in) begin
			rdata_r <= 32'h0000_0000;
			ack_r <= 1'h0;
		end else begin
			ack_r <= cfg_rd_in | cfg_wr_in;
			if (cfg_rd_in) begin
				if (dword_hit_cap) begin
					rdata_r <= cap_dword; // [R01]
				end else if (dword_hit_cs) begin
					rdata_r <= cs_dword;
				end else begin
					rdata_r <= 32'h0000_0000;
				end
			end
		end
	end

	// open drain: drive low while held status is enabled, or straight from the card
	// status pin so a wake still leaves with the bus clock stopped
	assign wake_pin_oe_out = wake_enable_flag_r & (wake_status_flag_r |
		(state_allowed & card_status_chg_in)); // [R04] [R11] [R14]
	assign wake_pin_out = 1'h0;
	assign cfg_rdata_out = rdata_r;
	assign cfg_ack_out = ack_r;
	assign power_state_out = power_state_r;
endmodule

// File: logic/pm_cap_regs.svh
/*
 * Offsets, field positions, fixed values and reset values of the power-management
 * capability block. Assumes byte offsets within one function's configuration space.
 */
`ifndef PM_CAP_REGS_SVH
`define PM_CAP_REGS_SVH

// configuration byte offsets
`define PM_CAP_ID_OFS 8'hDC
`define PM_NEXT_PTR_OFS 8'hDD
`define PM_CAP_WORD_OFS 8'hDE
`define PM_CTRL_STAT_OFS 8'hE0
`define PM_DATA_OFS 8'hE3

// fixed list entries
`define PM_CAP_ID_VAL 8'h01
`define PM_NEXT_PTR_VAL 8'h00

// capability word fields
`define PM_CAP_AUX_WAKE_BIT 15
`define PM_CAP_STATE_MASK_LSB 11
`define PM_CAP_STATE_MASK_VAL 4'hF
`define PM_CAP_AUX_WAKE_VAL 1'h1
`define PM_CAP_DEEP_DOZE_BIT 10
`define PM_CAP_LIGHT_DOZE_BIT 9
`define PM_CAP_AUX_CUR_LSB 6
`define PM_CAP_AUX_CUR_VAL 3'h0
`define PM_CAP_DSI_BIT 5
`define PM_CAP_BUS_CLK_BIT 3
`define PM_CAP_VERSION_VAL 3'h2
`define PM_CAP_WORD_RESET 16'hFE0A

// control/status fields
`define PM_CS_BPCC_BIT 23
`define PM_CS_B2B3_BIT 22
`define PM_CS_STATUS_BIT 15
`define PM_CS_SCALE_LSB 13
`define PM_CS_SCALE_VAL 2'h2
`define PM_CS_SELECT_LSB 9
`define PM_CS_ENABLE_BIT 8
`define PM_CS_STATE_LSB 0
`define PM_CS_RESET 24'hC04000
`define PM_DATA_VAL 8'h24

`endif

// File: logic/pm_cap_pkg.sv
/*
 * Types shared by the power-management capability block.
 * Assumes the constants of pm_cap_regs.svh are included where offsets are needed.
 */
package pm_cap_pkg;
	// current power state encoding of the control/status register
	typedef enum logic [1:0] {
		PS_D0 = 2'h0,
		PS_D1 = 2'h1,
		PS_D2 = 2'h2,
		PS_D3 = 2'h3
	} power_state_e;

	typedef logic [3:0] state_mask_t;
endpackage

// File: logic/wake_event_sync.sv
/*
 * Synchronises the card-side wake sources and turns each change into a one-cycle pulse.
 * Assumes all inputs are asynchronous pins and clock_in is the running bus clock.
 */
`timescale 1ns/100ps

module wake_event_sync #(
	parameter int WIDTH = 4
) (
	input wire logic clock_in,
	input wire logic rst_in,
	input wire logic [WIDTH-1:0] src_in,
	output logic [WIDTH-1:0] level_out,
	output logic [WIDTH-1:0] change_out
);
	logic [WIDTH-1:0] meta_r;
	logic [WIDTH-1:0] sync_r;
	logic [WIDTH-1:0] last_r;

	// two-stage synchroniser; meta_r feeds only sync_r
	always_ff @(posedge clock_in) begin
		if (rst_in) begin
			meta_r <= '0;
			sync_r <= '0;
		end else begin
			meta_r <= src_in;
			sync_r <= meta_r;
		end
	end

	// previous settled level for change detection
	always_ff @(posedge clock_in) begin
		if (rst_in) begin
			last_r <= '0;
		end else begin
			last_r <= sync_r;
		end
	end

	assign level_out = sync_r;
	assign change_out = sync_r ^ last_r;
endmodule

// File: tb/pm_capability_word_properties.sv
/* checker for pm_capability_word port relations.
   assumes binding to the design top, sampled on rising clock_in. */
`timescale 1ns/100ps
module pm_cap_checker (
	input wire logic clock_in,
	input wire logic rst_in,
	input wire logic [7:0] cfg_addr_in,
	input wire logic cfg_rd_in,
	input wire logic cfg_wr_in,
	input wire logic [3:0] cfg_be_in,
	input wire logic [31:0] cfg_wdata_in,
	input wire logic [31:0] cfg_rdata_out,
	input wire logic cfg_ack_out,
	input wire logic card_status_chg_in,
	input wire logic wake_pin_out,
	input wire logic wake_pin_oe_out,
	input wire logic [1:0] power_state_out
);
	default clocking @(posedge clock_in); endclocking
	default disable iff (rst_in);
	// dword decodes; only address bits 7:2 matter
	wire rd_cap = cfg_rd_in && cfg_addr_in[7:2] == 6'h37;
	wire rd_none = cfg_rd_in && cfg_addr_in[7:2] != 6'h37 && cfg_addr_in[7:2] != 6'h38;
	wire wr_cs = cfg_wr_in && cfg_addr_in[7:2] == 6'h38;
	ack_timing_a: assert property (cfg_ack_out == $past(cfg_rd_in || cfg_wr_in))
		else $error("ack not one cycle after request");
	cap_word_a: assert property (rd_cap |=> cfg_rdata_out == 32'hFE0A0001)
		else $error("capability dword wrong");
	unmapped_zero_a: assert property (rd_none |=> cfg_rdata_out == 32'h0)
		else $error("unmapped read not zero");
	rdata_hold_a: assert property (!$past(cfg_rd_in) && !$past(rst_in) |-> $stable(cfg_rdata_out))
		else $error("read data moved without read");
	pin_low_a: assert property (wake_pin_out == 1'h0)
		else $error("wake pin data not low");
	// release only by a write or by the raw card status level falling
	oe_release_a: assert property ($fell(wake_pin_oe_out) && !$past(rst_in) |->
		$past(cfg_wr_in) || $fell(card_status_chg_in)) else $error("wake released early");
	en_clear_a: assert property (wr_cs && cfg_be_in[1] && !cfg_wdata_in[8] |=>
		!wake_pin_oe_out) else $error("wake driven while disabled");
	power_state_a: assert property (wr_cs && cfg_be_in[0] |=>
		power_state_out == $past(cfg_wdata_in[1:0])) else $error("power state not written");
	cover property (rd_cap);
	cover property ($rose(wake_pin_oe_out));
	cover property ($fell(wake_pin_oe_out));
endmodule
bind pm_capability_word pm_cap_checker chk (
	.clock_in(clock_in),
	.rst_in(rst_in),
	.cfg_addr_in(cfg_addr_in),
	.cfg_rd_in(cfg_rd_in),
	.cfg_wr_in(cfg_wr_in),
	.cfg_be_in(cfg_be_in),
	.cfg_wdata_in(cfg_wdata_in),
	.cfg_rdata_out(cfg_rdata_out),
	.cfg_ack_out(cfg_ack_out),
	.card_status_chg_in(card_status_chg_in),
	.wake_pin_out(wake_pin_out),
	.wake_pin_oe_out(wake_pin_oe_out),
	.power_state_out(power_state_out)
);

// File: tb/pm_capability_word_bench.sv
/* self-checking bench for pm_capability_word.
   assumes the checker is bound; inputs change on the falling edge. */
`timescale 1ns/100ps
module pm_capability_word_bench;
	logic clock_in = 0, rst_in = 1, run = 1, rd = 0, wr = 0, cs = 0, ack, pin, oe;
	logic [7:0] addr = 0;
	logic [3:0] be = 0;
	logic [2:0] ev = 0;
	logic [1:0] ps;
	logic [31:0] wd = 0, rdv, rdat;
	int err_total = 0, samples_checked = 0, cyc = 0, seed = 24916;
	// clock can be parked low to prove the clockless wake path
	always #4 if (run) clock_in = ~clock_in;
	pm_capability_word dut (.clock_in(clock_in), .rst_in(rst_in), .cfg_addr_in(addr),
		.cfg_rd_in(rd), .cfg_wr_in(wr), .cfg_be_in(be), .cfg_wdata_in(wd),
		.cfg_rdata_out(rdat), .cfg_ack_out(ack), .card_detect_in(ev[0]),
		.ready_busy_in(ev[1]), .battery_warn_in(ev[2]), .card_status_chg_in(cs),
		.wake_pin_out(pin), .wake_pin_oe_out(oe), .power_state_out(ps));
	// expected word built field by field, top bit first
	function automatic logic [15:0] cap_exp();
		return {1'h1, 4'hF, 1'h1, 1'h1, 3'h0, 1'h0, 1'h0, 1'h1, 3'h2};
	endfunction
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		samples_checked++;
		if (got !== exp) begin
			err_total++;
			$display("[FAIL] %0t got %h want %h", $time, got, exp);
		end
	endtask
	// one request per call; a full cycle passes before the next strobe
	task automatic acc(input logic w, input logic [7:0] a, input logic [3:0] b,
		input logic [31:0] d);
		@(negedge clock_in);
		rd = !w;
		wr = w;
		addr = a;
		be = b;
		wd = d;
		@(negedge clock_in);
		rdv = rdat;
		rd = 0;
		wr = 0;
		chk(ack, 1);
	endtask
	task automatic reset2();
		rst_in = 1;
		repeat (2) @(negedge clock_in);
		rst_in = 0;
	endtask
	task automatic evt(input int k);
		@(negedge clock_in);
		ev[k] = ~ev[k];
		repeat (5) @(negedge clock_in);
	endtask
	task automatic tally_and_finish();
		$display("checks %0d errors %0d", samples_checked, err_total);
		if (err_total == 0 && samples_checked > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	// hang guard, well above the roughly 115 cycles the run needs
	always @(posedge clock_in) begin
		cyc++;
		if (cyc > 4000) begin
			err_total++;
			tally_and_finish();
		end
	end
	initial begin
		reset2();
		acc(0, 8'hDC, 4'h0, 0);
		chk(rdv, {cap_exp(), 16'h0001});
		for (int i = 0; i < 4; i++) begin
			acc(1, 8'hDE, 4'hF, $random(seed));
			acc(0, 8'hDE, 4'h0, 0);
			chk(rdv, {cap_exp(), 16'h0001});
			addr = 8'($random(seed));
			// both mapped dwords are steered away so only unmapped space is read
			acc(0, (addr[7:3] inside {5'h1B, 5'h1C}) ? 8'h10 : addr, 4'h0, 0);
			chk(rdv, 0);
		end
		acc(1, 8'hE0, 4'h2, 32'h100);
		// wake from every power state, held until one is written to status
		for (int s = 0; s < 4; s++) begin
			acc(1, 8'hE0, 4'h1, s);
			chk(ps, s);
			evt(s % 3);
			chk(oe, 1);
			acc(1, 8'hE0, 4'h2, 32'h100);
			chk(oe, 1);
			acc(1, 8'hE0, 4'h2, 32'h8100);
			chk(oe, 0);
		end
		evt(1);
		acc(1, 8'hE0, 4'h2, 0);
		chk(oe, 0);
		evt(2);
		acc(0, 8'hE0, 4'h0, 0);
		chk({oe, rdv[15]}, 2'h1);
		acc(1, 8'hE0, 4'h2, 32'h8100);
		@(negedge clock_in);
		run = 0;
		cs = 1;
		#20 chk(oe, 1);
		run = 1;
		repeat (6) @(negedge clock_in);
		cs = 0;
		#1 chk(oe, 1);
		acc(1, 8'hE0, 4'h3, 32'h8103);
		chk(oe, 0);
		// all ones: fixed fields and the data byte must not move
		acc(1, 8'hE0, 4'hF, 32'hFFFF_FFFF);
		acc(0, 8'hE0, 4'h0, 0);
		chk({oe, rdv}, {1'h0, 32'h24C05F03});
		reset2();
		acc(0, 8'hE0, 4'h0, 0);
		chk({pin, oe, ps, rdv}, {4'h0, 32'h24C04000});
		tally_and_finish();
	end
endmodule
